//--- hdl/ppsp_pkg.sv
/*
 * Package for the per-port status page: register offsets, field positions,
 * speed encodings, reset values and timing constants.
 * Assumes a 250 MHz system clock and a 32-bit Avalon-MM register slave.
 */
package ppsp_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ---------------------------------------------------------------
    localparam logic [5:0] PPSP_OFS_SELECT = 6'h00; // port select
    localparam logic [5:0] PPSP_OFS_CTRL = 6'h04; // enables and clear-on-1 flags
    localparam logic [5:0] PPSP_OFS_SPEED = 6'h08; // speed fields and mode bits
    localparam logic [5:0] PPSP_OFS_ERRCNT = 6'h0C; // invalid codeword counter
    localparam logic [5:0] PPSP_OFS_STATE = 6'h10; // live per-port state

    // ---------------------------------------------------------------
    // control word field positions
    // ---------------------------------------------------------------
    localparam int PPSP_BIT_EVT_EN = 0;
    localparam int PPSP_BIT_EVT_FLAG = 1;
    localparam int PPSP_BIT_SUSP_ERR = 2;
    localparam int PPSP_BIT_IDLE_ERR = 3;
    localparam int PPSP_BIT_SCRAM_OFF = 4;
    localparam int PPSP_BIT_UNRELIABLE = 5;

    // speed word field positions
    localparam int PPSP_POS_CEILING = 0; // bits 2:0
    localparam int PPSP_POS_CAPABLE = 4; // bits 6:4
    localparam int PPSP_BIT_FAST_ONLY = 8;
    localparam int PPSP_BIT_OWN_PLUG = 9;
    localparam int PPSP_BIT_FAST_ACTIVE = 10;

    // state word field positions
    localparam int PPSP_BIT_ATTACH = 0;
    localparam int PPSP_BIT_RX_BIAS = 1;
    localparam int PPSP_BIT_LEGACY_SEEN = 2;
    localparam int PPSP_BIT_LEGACY_ACT = 3;
    localparam int PPSP_BIT_CYCLE_BREAK = 4;
    localparam int PPSP_BIT_LOW_IDLE = 5;

    // ---------------------------------------------------------------
    // speed encodings
    // ---------------------------------------------------------------
    localparam logic [2:0] PPSP_S100 = 3'h0;
    localparam logic [2:0] PPSP_S200 = 3'h1;
    localparam logic [2:0] PPSP_S400 = 3'h2;
    localparam logic [2:0] PPSP_S800 = 3'h3;
    localparam logic [2:0] PPSP_S1600 = 3'h4;
    localparam logic [2:0] PPSP_S3200 = 3'h5;
    localparam logic [2:0] PPSP_SPEED_RSVD = 3'h7;

    // ---------------------------------------------------------------
    // constants and timing
    // ---------------------------------------------------------------
    localparam logic [7:0] PPSP_ERR_MAX = 8'hFF;
    localparam logic PPSP_FAST_ONLY_VAL = 1'b0;
    localparam logic PPSP_OWN_PLUG_VAL = 1'b1;
    localparam int PPSP_CLK_MHZ = 250;
    localparam int PPSP_DEBOUNCE_MS = 341;
    localparam longint PPSP_DEBOUNCE_CYC = longint'(PPSP_DEBOUNCE_MS) * 1000 * PPSP_CLK_MHZ;

    // per-port live inputs bundled together
    typedef struct packed {
        logic rawConnect;      // undebounced physical connection
        logic rxBiasValid;     // receive_bias_valid
        logic legacySeen;      // legacy_bias_attach_seen
        logic fastActive;      // operating in Beta mode
        logic loopHeld;        // held by loop-free build
        logic inStandby;       // standby power state
        logic resumeNoBias;    // resume fault event
        logic suspendBias;     // suspend fault event
        logic standbyErr;      // error during standby
        logic negFail;         // speed negotiation or sync failure
        logic badCodeword;     // invalid codeword pulse
        logic portEvent;       // port event pulse
    } ppsp_port_in_t;

endpackage : ppsp_pkg

//--- hdl/ppsp_port_status_page.sv
/*
 * Per-port status and control page of a multi-port serial-bus cable PHY.
 * Registers are reached over Avalon-MM; fields follow the port select.
 * Assumes per-port status inputs synchronous to clock, remote clears as
 * pulses from the packet engine, bus reset as a one-cycle pulse.
 */
`timescale 1ns/1ns
`default_nettype none

// Operation
// - enabled port event sets event flag and notifies link; hw reset clears enable
// - resume without bias or suspend with bias sets fault and holds port suspended
// - writing one clears the fault flag; hw reset clears, bus reset keeps
// - standby error sets idle error flag; leaving standby clears it
// - write one or remote command clears idle error and latched standby errors
// - scrambling-off bit set sends transmit data unscrambled
// - fast-only capability bit reads zero on every port
// - legacy attach bit reads one when dc legacy connection detected
// - three-bit speed ceiling limits Beta speed, encodings S100 to S3200
// - ceiling writes above capability store the capable speed
// - ceiling resets to capable speed, used only when new Beta link forms
// - own connector present flag reads one whenever the selected port exists
// - capable speed field reports port maximum, same encoding
// - negotiation or sync failure sets unreliable flag; writing one clears it
// - fast-active bit reads one in Beta mode while attached, zero otherwise
// - legacy active when attached, bias valid, and not fast-active
// - eight-bit invalid codeword counter increments, saturates at 255
// - any read of the counter, local or remote, clears it
// - cycle-break flag reads loop-disable hold; bus reset or disconnect clears
// - low-power-idle flag reads one while port in standby
// - attach status sets only after connection stable for 341 ms
module ppsp_port_status_page
    import ppsp_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter int SEL_W = 2,
    parameter longint DEBOUNCE_CYC = PPSP_DEBOUNCE_CYC,
    parameter logic [2:0] CAPABLE_SPEED = PPSP_S800,
    parameter logic [2:0] MIN_SPEED = PPSP_S100
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic busReset,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire ppsp_port_in_t [NUM_PORTS-1:0] portIn,
    input wire logic [NUM_PORTS-1:0] remoteIdleClear,
    input wire logic [NUM_PORTS-1:0] remoteErrRead,
    output logic linkNotify,
    output logic [NUM_PORTS-1:0] holdSuspended,
    output logic [NUM_PORTS-1:0] scrambleOff,
    output logic [NUM_PORTS-1:0] standbyErrClear,
    output logic [NUM_PORTS-1:0][2:0] trainSpeed
);

    // ---------------------------------------------------------------
    // bus slave: one wait cycle, answer on the second edge
    // ---------------------------------------------------------------
    logic busy;
    logic ack;
    logic [SEL_W-1:0] portSel;
    logic [NUM_PORTS-1:0] evtEn;
    logic [NUM_PORTS-1:0] evtFlag;
    logic [NUM_PORTS-1:0] suspErr;
    logic [NUM_PORTS-1:0] idleErr;
    logic [NUM_PORTS-1:0] scramOff;
    logic [NUM_PORTS-1:0] unreliable;
    logic [NUM_PORTS-1:0][2:0] ceiling;
    logic [NUM_PORTS-1:0][7:0] errCount;
    logic [NUM_PORTS-1:0] attached;
    logic [NUM_PORTS-1:0] cycleBreak;
    logic [NUM_PORTS-1:0] fastPrev;

    // request accepted on the edge where ack is high
    assign ack = busy;
    assign waitrequest = (read | write) & ~ack;

    // ack rises one cycle after a request appears, then drops
    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (read | write) & ~busy;
        end
    end

    logic wrEn;
    logic rdEn;
    assign wrEn = write & ack & byteenable[0];
    assign rdEn = read & ack;

    // port select register
    always_ff @(posedge clock) begin
        if (rst) begin
            portSel <= '0;
        end else if (wrEn && address == PPSP_OFS_SELECT) begin
            portSel <= writedata[SEL_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // per-port field storage
    // ---------------------------------------------------------------
    localparam int DC_W = 40;
    localparam logic [DC_W-1:0] DC_MAX = DC_W'(DEBOUNCE_CYC - 1);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic hit;
            logic wrCtrl;
            logic wrSpeed;
            logic rdErr;
            logic [DC_W-1:0] dbCount;
            logic [2:0] next_ceiling;

            assign hit = (portSel == SEL_W'(p));
            assign wrCtrl = wrEn && hit && address == PPSP_OFS_CTRL;
            assign wrSpeed = wrEn && hit && address == PPSP_OFS_SPEED;
            assign rdErr = (rdEn && hit && address == PPSP_OFS_ERRCNT) | remoteErrRead[p];

            // event enable, hw reset only
            always_ff @(posedge clock) begin
                if (rst) begin
                    evtEn[p] <= 1'b0;
                end else if (wrCtrl) begin
                    evtEn[p] <= writedata[PPSP_BIT_EVT_EN];
                end
            end

            // event flag: set wins over write-one clear
            always_ff @(posedge clock) begin
                if (rst) begin
                    evtFlag[p] <= 1'b0;
                end else if (evtEn[p] && portIn[p].portEvent) begin
                    evtFlag[p] <= 1'b1;
                end else if (wrCtrl && writedata[PPSP_BIT_EVT_FLAG]) begin
                    evtFlag[p] <= 1'b0;
                end
            end

            // suspend/resume fault flag
            always_ff @(posedge clock) begin
                if (rst) begin
                    suspErr[p] <= 1'b0;
                end else if (portIn[p].resumeNoBias || portIn[p].suspendBias) begin
                    suspErr[p] <= 1'b1;
                end else if (wrCtrl && writedata[PPSP_BIT_SUSP_ERR]) begin
                    suspErr[p] <= 1'b0;
                end
            end

            // idle power error flag
            always_ff @(posedge clock) begin
                if (rst) begin
                    idleErr[p] <= 1'b0;
                end else if (portIn[p].standbyErr && portIn[p].inStandby) begin
                    idleErr[p] <= 1'b1;
                end else if (!portIn[p].inStandby) begin
                    idleErr[p] <= 1'b0;
                end else if ((wrCtrl && writedata[PPSP_BIT_IDLE_ERR]) || remoteIdleClear[p]) begin
                    idleErr[p] <= 1'b0;
                end
            end

            // pulse to clear latched standby errors along with the flag
            assign standbyErrClear[p] = (wrCtrl && writedata[PPSP_BIT_IDLE_ERR])
                                        || remoteIdleClear[p];

            // scrambler off and unreliable flag
            always_ff @(posedge clock) begin
                if (rst) begin
                    scramOff[p] <= 1'b0;
                end else if (wrCtrl) begin
                    scramOff[p] <= writedata[PPSP_BIT_SCRAM_OFF];
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    unreliable[p] <= 1'b0;
                end else if (portIn[p].negFail) begin
                    unreliable[p] <= 1'b1;
                end else if (wrCtrl && writedata[PPSP_BIT_UNRELIABLE]) begin
                    unreliable[p] <= 1'b0;
                end
            end

            // speed ceiling: clamp between minimum and capability
            always_comb begin
                next_ceiling = writedata[PPSP_POS_CEILING +: 3];
                if (next_ceiling > CAPABLE_SPEED) begin
                    next_ceiling = CAPABLE_SPEED;
                end else if (next_ceiling < MIN_SPEED) begin
                    next_ceiling = MIN_SPEED;
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    ceiling[p] <= CAPABLE_SPEED;
                end else if (wrSpeed) begin
                    ceiling[p] <= next_ceiling;
                end
            end

            // training speed latched only when a new Beta link comes up
            always_ff @(posedge clock) begin
                if (rst) begin
                    fastPrev[p] <= 1'b0;
                    trainSpeed[p] <= CAPABLE_SPEED;
                end else begin
                    fastPrev[p] <= portIn[p].fastActive;
                    if (portIn[p].fastActive && !fastPrev[p]) begin
                        trainSpeed[p] <= ceiling[p];
                    end
                end
            end

            // invalid codeword counter: read clear wins, a coincident codeword counts as one
            always_ff @(posedge clock) begin
                if (rst) begin
                    errCount[p] <= '0;
                end else if (rdErr) begin
                    errCount[p] <= portIn[p].badCodeword ? 8'h01 : 8'h00;
                end else if (portIn[p].badCodeword && errCount[p] != PPSP_ERR_MAX) begin
                    errCount[p] <= errCount[p] + 8'h01;
                end
            end

            // connection debounce
            always_ff @(posedge clock) begin
                if (rst) begin
                    dbCount <= '0;
                    attached[p] <= 1'b0;
                end else if (!portIn[p].rawConnect) begin
                    dbCount <= '0;
                    attached[p] <= 1'b0;
                end else if (dbCount >= DC_MAX) begin
                    attached[p] <= 1'b1;
                end else begin
                    dbCount <= dbCount + DC_W'(1);
                end
            end

            // cycle-break follows loop hold, cleared by bus reset or disconnect
            always_ff @(posedge clock) begin
                if (rst) begin
                    cycleBreak[p] <= 1'b0;
                end else if (busReset || !portIn[p].rawConnect) begin
                    cycleBreak[p] <= 1'b0;
                end else begin
                    cycleBreak[p] <= portIn[p].loopHeld;
                end
            end

            assign holdSuspended[p] = suspErr[p];
            assign scrambleOff[p] = scramOff[p];
        end
    endgenerate

    // link notified while any enabled port has an event pending
    assign linkNotify = |(evtFlag & evtEn);

    // ---------------------------------------------------------------
    // read mux for the selected port
    // ---------------------------------------------------------------
    logic [31:0] next_readdata;
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (portSel < SEL_W'(NUM_PORTS)) begin
            case (address)
                PPSP_OFS_SELECT: next_readdata[SEL_W-1:0] = portSel;
                PPSP_OFS_CTRL: begin
                    next_readdata[PPSP_BIT_EVT_EN] = evtEn[portSel];
                    next_readdata[PPSP_BIT_EVT_FLAG] = evtFlag[portSel];
                    next_readdata[PPSP_BIT_SUSP_ERR] = suspErr[portSel];
                    next_readdata[PPSP_BIT_IDLE_ERR] = idleErr[portSel];
                    next_readdata[PPSP_BIT_SCRAM_OFF] = scramOff[portSel];
                    next_readdata[PPSP_BIT_UNRELIABLE] = unreliable[portSel];
                end
                PPSP_OFS_SPEED: begin
                    next_readdata[PPSP_POS_CEILING +: 3] = ceiling[portSel];
                    next_readdata[PPSP_POS_CAPABLE +: 3] = CAPABLE_SPEED;
                    next_readdata[PPSP_BIT_FAST_ONLY] = PPSP_FAST_ONLY_VAL;
                    next_readdata[PPSP_BIT_OWN_PLUG] = PPSP_OWN_PLUG_VAL;
                    next_readdata[PPSP_BIT_FAST_ACTIVE] = portIn[portSel].fastActive
                                                          & attached[portSel];
                end
                PPSP_OFS_ERRCNT: next_readdata[7:0] = errCount[portSel];
                PPSP_OFS_STATE: begin
                    next_readdata[PPSP_BIT_ATTACH] = attached[portSel];
                    next_readdata[PPSP_BIT_RX_BIAS] = portIn[portSel].rxBiasValid;
                    next_readdata[PPSP_BIT_LEGACY_SEEN] = portIn[portSel].legacySeen;
                    next_readdata[PPSP_BIT_LEGACY_ACT] = attached[portSel]
                        & portIn[portSel].rxBiasValid
                        & ~(portIn[portSel].fastActive & attached[portSel]);
                    next_readdata[PPSP_BIT_CYCLE_BREAK] = cycleBreak[portSel];
                    next_readdata[PPSP_BIT_LOW_IDLE] = portIn[portSel].inStandby;
                end
                default: next_readdata = 32'h0000_0000;
            endcase
        end else if (address == PPSP_OFS_SELECT) begin
            next_readdata[SEL_W-1:0] = portSel;
        end
    end

    // read data registered, valid while ack is high
    always_ff @(posedge clock) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else begin
            readdata <= next_readdata;
        end
    end

endmodule // ppsp_port_status_page

`default_nettype wire

//--- test/ppsp_port_status_page_properties.sv
/*
 * Checker for the status page: handshake, speed fields, sticky flags, notify.
 * Assumes it sees only the top module's ports.
 */
`timescale 1ns/1ns
`default_nettype none
module ppsp_port_status_page_properties
    import ppsp_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter logic [2:0] CAPABLE_SPEED = PPSP_S800
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire ppsp_port_in_t [NUM_PORTS-1:0] portIn,
    input wire logic [NUM_PORTS-1:0] remoteIdleClear,
    input wire logic linkNotify,
    input wire logic [NUM_PORTS-1:0] holdSuspended,
    input wire logic [NUM_PORTS-1:0] scrambleOff,
    input wire logic [NUM_PORTS-1:0] standbyErrClear
);
    // ---------------------------------------------------------------
    // handshake and register checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // request waiting, then answered
    sequence reqWaiting;
        (read || write) && waitrequest;
    endsequence
    sequence reqAnswered;
        (read || write) && !waitrequest;
    endsequence
    AST_ONE_WAIT: assert property (reqWaiting |=> reqAnswered)
        else $error("no answer after one wait");
    AST_IDLE_NO_WAIT: assert property (!(read || write) |-> !waitrequest)
        else $error("wait without request");
    AST_SPEED_FIXED: assert property (
        reqAnswered ##0 (read && address == PPSP_OFS_SPEED) |-> !readdata[8] && readdata[9]
        && readdata[6:4] == CAPABLE_SPEED && readdata[2:0] <= CAPABLE_SPEED)
        else $error("speed fields wrong");
    AST_LINK_HOLD: assert property (linkNotify && !write |=> linkNotify)
        else $error("notify dropped without write");
    AST_SCRAM_STABLE: assert property (!write |=> $stable(scrambleOff))
        else $error("scramble changed without write");
    // per-port fault and clear relations
    for (genvar i = 0; i < NUM_PORTS; i++) begin : gPort
        AST_FAULT_SET: assert property (
            (portIn[i].resumeNoBias || portIn[i].suspendBias) |=> holdSuspended[i])
            else $error("fault did not suspend port");
        AST_FAULT_STICKY: assert property (holdSuspended[i] && !write |=> holdSuspended[i])
            else $error("fault dropped without write");
        AST_REMOTE_CLEAR: assert property (remoteIdleClear[i] |-> standbyErrClear[i])
            else $error("remote clear missed");
    end
endmodule // ppsp_port_status_page_properties
`default_nettype wire

//--- test/ppsp_port_model.sv
/*
 * Port-side model: live per-port status and remote packet pulses.
 * Assumes its tasks are called right after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module ppsp_port_model
    import ppsp_pkg::*;
#(
    parameter int NUM_PORTS = 3
) (
    input wire logic clock,
    output var ppsp_port_in_t [NUM_PORTS-1:0] portIn,
    output logic [NUM_PORTS-1:0] remoteIdleClear,
    output logic [NUM_PORTS-1:0] remoteErrRead
);
    // ---------------------------------------------------------------
    // held levels with one-shot events on top
    // ---------------------------------------------------------------
    ppsp_port_in_t [NUM_PORTS-1:0] lvl = '0;
    ppsp_port_in_t [NUM_PORTS-1:0] ev = '0;
    assign portIn = lvl | ev;
    // remote packet pulses idle low
    initial begin
        remoteIdleClear = '0;
        remoteErrRead = '0;
    end
    task automatic setLevel(input int p, input ppsp_port_in_t v);
        lvl[p] <= v;
    endtask
    // each high cycle of an event counts once
    task automatic pulse(input int p, input ppsp_port_in_t m, input int n);
        ev[p] <= m;
        repeat (n) @(posedge clock);
        ev[p] <= '0;
    endtask
    task automatic remote(input int p, input logic idle, input logic errRead);
        remoteIdleClear[p] <= idle;
        remoteErrRead[p] <= errRead;
        @(posedge clock);
        remoteIdleClear[p] <= 1'b0;
        remoteErrRead[p] <= 1'b0;
    endtask
endmodule // ppsp_port_model
`default_nettype wire

//--- test/testbench.sv
/*
 * Self-checking bench for the status page, one task per scenario.
 * Assumes a 250 MHz clock and a debounce count of 8 cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ppsp_pkg::*;
    localparam logic [2:0] CAP = PPSP_S800;
    // masks in reverse struct field order, from bit 0 up
    localparam ppsp_port_in_t M_EVT = 12'h001, M_BAD = 12'h002, M_NEG = 12'h004, M_SERR = 12'h008;
    localparam ppsp_port_in_t M_SBIAS = 12'h010, M_RNB = 12'h020, M_STBY = 12'h040, M_LOOP = 12'h080;
    localparam ppsp_port_in_t M_FAST = 12'h100, M_LEG = 12'h200, M_RX = 12'h400, M_CONN = 12'h800;
    logic clock, rst, busReset, read, write, waitrequest, linkNotify;
    logic [5:0] address;
    logic [31:0] writedata, readdata;
    logic [2:0] holdSuspended, scrambleOff, standbyErrClear, remoteIdleClear, remoteErrRead;
    logic [2:0][2:0] trainSpeed;
    ppsp_port_in_t [2:0] portIn;
    int numErrors = 0;
    int testsRun = 0;
    ppsp_port_status_page #(.DEBOUNCE_CYC(8)) dut (.clock, .rst, .busReset, .address, .read,
        .write, .writedata, .byteenable(4'hF), .readdata, .waitrequest, .portIn,
        .remoteIdleClear, .remoteErrRead, .linkNotify, .holdSuspended, .scrambleOff,
        .standbyErrClear, .trainSpeed);
    ppsp_port_model ports (.clock, .portIn, .remoteIdleClear, .remoteErrRead);
    // ---------------------------------------------------------------
    // clock, bus tasks and checks
    // ---------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // hold request until waitrequest is sampled low
    task automatic busOp(input logic isWr, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        address <= a;
        writedata <= d;
        write <= isWr;
        read <= !isWr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        busOp(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        busOp(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask
    task automatic pulseBusReset();
        busReset <= 1'b1;
        @(posedge clock);
        busReset <= 1'b0;
    endtask
    function automatic logic [31:0] spd(input logic [2:0] ceil, input logic fast);
        spd = 32'(ceil) | (32'(CAP) << 4) | 32'h200 | (32'(fast) << 10);
    endfunction
    task automatic finishTest();
        $display("checks %0d errors %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic testResetSpeed();
        rd(PPSP_OFS_CTRL, 32'h0, "ctrl");
        rd(PPSP_OFS_SPEED, spd(CAP, 1'b0), "speed");
        chk("trainSpeed", 32'(CAP), 32'(trainSpeed[0]));
        for (int v = 0; v < 8; v++) begin
            wr(PPSP_OFS_SPEED, 32'(v));
            rd(PPSP_OFS_SPEED, spd((v > CAP) ? CAP : 3'(v), 1'b0), "ceiling");
        end
    endtask
    task automatic testEvent();
        wr(PPSP_OFS_CTRL, 32'h1);
        ports.pulse(0, M_EVT, 1);
        @(posedge clock);
        chk("linkNotify", 32'h1, 32'(linkNotify));
        pulseBusReset();
        rd(PPSP_OFS_CTRL, 32'h3, "ctrl");
        wr(PPSP_OFS_CTRL, 32'h2);
        ports.pulse(0, M_EVT, 1);
        rd(PPSP_OFS_CTRL, 32'h0, "ctrl");
        chk("linkNotify", 32'h0, 32'(linkNotify));
    endtask
    task automatic testFaults();
        ppsp_port_in_t m [3] = '{M_RNB, M_SBIAS, M_NEG};
        logic [31:0] bitv [3] = '{32'h4, 32'h4, 32'h20};
        foreach (m[i]) begin
            ports.pulse(0, m[i], 1);
            pulseBusReset();
            chk("holdSuspended", {31'h0, i < 2}, 32'(holdSuspended[0]));
            rd(PPSP_OFS_CTRL, bitv[i], "faultFlag");
            wr(PPSP_OFS_CTRL, bitv[i]);
            rd(PPSP_OFS_CTRL, 32'h0, "faultFlag");
        end
    endtask
    task automatic testIdle();
        ports.setLevel(0, M_STBY);
        ports.pulse(0, M_SERR, 1);
        rd(PPSP_OFS_CTRL, 32'h8, "idleErr");
        rd(PPSP_OFS_STATE, 32'h20, "lowIdle");
        ports.setLevel(0, '0);
        @(posedge clock);
        rd(PPSP_OFS_CTRL, 32'h0, "idleErr");
        rd(PPSP_OFS_STATE, 32'h0, "lowIdle");
        ports.setLevel(0, M_STBY);
        ports.pulse(0, M_SERR, 1);
        ports.remote(0, 1'b1, 1'b0);
        rd(PPSP_OFS_CTRL, 32'h0, "idleErr");
        ports.pulse(0, M_SERR, 1);
        wr(PPSP_OFS_CTRL, 32'h8);
        rd(PPSP_OFS_CTRL, 32'h0, "idleErr");
        ports.setLevel(0, '0);
    endtask
    task automatic testCounter();
        ports.pulse(0, M_BAD, 300);
        rd(PPSP_OFS_ERRCNT, 32'hFF, "errCount");
        rd(PPSP_OFS_ERRCNT, 32'h0, "errCount");
        ports.pulse(0, M_BAD, 5);
        rd(PPSP_OFS_ERRCNT, 32'h5, "errCount");
        ports.pulse(0, M_BAD, 2);
        ports.remote(0, 1'b0, 1'b1);
        rd(PPSP_OFS_ERRCNT, 32'h0, "errCount");
    endtask
    task automatic testState();
        wr(PPSP_OFS_SPEED, 32'h1);
        ports.setLevel(0, M_CONN | M_RX | M_FAST);
        rd(PPSP_OFS_STATE, 32'h2, "state");
        repeat (12) @(posedge clock);
        rd(PPSP_OFS_STATE, 32'h3, "state");
        rd(PPSP_OFS_SPEED, spd(3'h1, 1'b1), "speed");
        wr(PPSP_OFS_SPEED, 32'h2);
        chk("trainSpeed", 32'h1, 32'(trainSpeed[0]));
        ports.setLevel(0, M_CONN | M_RX | M_LEG | M_LOOP);
        @(posedge clock);
        rd(PPSP_OFS_STATE, 32'h1F, "state");
        rd(PPSP_OFS_SPEED, spd(3'h2, 1'b0), "speed");
        pulseBusReset();
        rd(PPSP_OFS_STATE, 32'h0F, "state");
        ports.setLevel(0, '0);
    endtask
    task automatic testSelect();
        wr(PPSP_OFS_SELECT, 32'h1);
        wr(PPSP_OFS_CTRL, 32'h11);
        chk("scrambleOff", 32'h2, 32'(scrambleOff));
        rd(PPSP_OFS_CTRL, 32'h11, "ctrl");
        wr(PPSP_OFS_SELECT, 32'h3);
        wr(PPSP_OFS_CTRL, 32'h10);
        rd(PPSP_OFS_CTRL, 32'h0, "ctrl");
        rd(6'h14, 32'h0, "unmapped");
        wr(PPSP_OFS_SELECT, 32'h0);
        rd(PPSP_OFS_CTRL, 32'h0, "ctrl");
        chk("scrambleOff", 32'h2, 32'(scrambleOff));
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        busReset = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        testResetSpeed();
        testEvent();
        testFaults();
        testIdle();
        testCounter();
        testState();
        testSelect();
        finishTest();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        numErrors++;
        finishTest();
    end
endmodule // testbench
bind ppsp_port_status_page ppsp_port_status_page_properties #(
    .NUM_PORTS(NUM_PORTS), .CAPABLE_SPEED(CAPABLE_SPEED)) props (.clock, .rst, .address, .read,
    .write, .readdata, .waitrequest, .portIn, .remoteIdleClear, .linkNotify, .holdSuspended,
    .scrambleOff, .standbyErrClear);
`default_nettype wire
